// ==== hw/dtc_defines.svh ====
// Purpose: Offsets, field positions, reset values and counts for dtc
// Assumes: Included by bare name
// Notes: Register index is printed offset; byte address is index times four
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

`define DTC_CTRL_INDEX    6'h01
`define DTC_RESET_VALUE   8'h00

`define DTC_BIT_MODE      7
`define DTC_BIT_ROUTE     6
`define DTC_BIT_FUNC_HI   5
`define DTC_BIT_FUNC_LO   4
`define DTC_BIT_BEH_HI    3
`define DTC_BIT_BEH_LO    2
`define DTC_BIT_SHORT     1
`define DTC_BIT_LONG      0

`define DTC_FUNC_AND      2'h0
`define DTC_FUNC_OR       2'h1
`define DTC_FUNC_NOR      2'h2
`define DTC_FUNC_NAND     2'h3

`define DTC_BEH_NORMAL    2'h0
`define DTC_BEH_PINGPONG  2'h1
`define DTC_BEH_FORCE0    2'h2
`define DTC_BEH_FORCE1    2'h3

`define DTC_EDGE_FALL     2'h0
`define DTC_EDGE_RISE     2'h1
`define DTC_EDGE_BOTH     2'h2

`define DTC_FILT_NONE     2'h0
`define DTC_FILT_SHORT    2'h1
`define DTC_FILT_LONG     2'h2
`define DTC_FILT_CYC_S    4'h4
`define DTC_FILT_CYC_L    4'h8
`define DTC_FILT_CYC_0    4'h1

`endif

// ==== hw/dtc_pkg.sv ====
// Purpose: Shared types for dtc
// Assumes: Codes live in dtc_defines.svh
// Notes: None
package dtc_pkg;
  typedef logic [1:0] dtc_sel_t;
  typedef logic [7:0] dtc_byte_t;
  typedef logic [3:0] dtc_cnt_t;
endpackage

// ==== hw/dtc_edge_filter.sv ====
// Purpose: Noise filter and edge detector for the demodulator input
// Assumes: raw_in synchronous to pclk; pclk is the SCLK
// Notes: Events are one-cycle pulses from flip-flops
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_edge_filter (
  // Clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // Control
  input  wire logic            enable,
  input  wire dtc_pkg::dtc_sel_t filt_sel,
  input  wire dtc_pkg::dtc_sel_t edge_sel,
  input  wire logic            raw_in,
  // Events
  output logic                 rise_evt,
  output logic                 fall_evt
);
  logic              level;
  logic              next_level;
  dtc_pkg::dtc_cnt_t run_cnt;
  dtc_pkg::dtc_cnt_t next_run_cnt;
  dtc_pkg::dtc_cnt_t limit;
  logic              next_rise;
  logic              next_fall;

  always_comb begin
    unique case (filt_sel)
      `DTC_FILT_SHORT: limit = `DTC_FILT_CYC_S;
      `DTC_FILT_LONG:  limit = `DTC_FILT_CYC_L;
      default:         limit = `DTC_FILT_CYC_0; // Reserved code filters nothing
    endcase
    next_level   = level;
    next_run_cnt = 4'h0;
    // New level accepted only after limit stable samples
    if (raw_in != level) begin
      if (run_cnt + 4'h1 >= limit) begin
        next_level = raw_in;
      end else begin
        next_run_cnt = run_cnt + 4'h1;
      end
    end
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (enable && next_level != level) begin
      unique case (edge_sel)
        `DTC_EDGE_FALL: next_fall = !next_level;
        `DTC_EDGE_RISE: next_rise = next_level;
        `DTC_EDGE_BOTH: begin
          next_rise = next_level;
          next_fall = !next_level;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level    <= 1'b0;
      run_cnt  <= 4'h0;
      rise_evt <= 1'b0;
      fall_evt <= 1'b0;
    end else begin
      level    <= next_level;
      run_cnt  <= next_run_cnt;
      rise_evt <= next_rise;
      fall_evt <= next_fall;
    end
  end
endmodule

// ==== hw/dtc_out_logic.sv ====
// Purpose: Combines timer outputs and routes the shared output pin
// Assumes: Timer outputs synchronous to pclk
// Notes: Outputs registered, one cycle behind inputs
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_out_logic (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Configuration
  input  wire logic              tx_mode,
  input  wire logic              route_en,
  input  wire dtc_pkg::dtc_sel_t func,
  input  wire dtc_pkg::dtc_sel_t beh,
  // Sources
  input  wire logic              short_in,
  input  wire logic              long_in,
  input  wire logic              port_data,
  // Results
  output logic                   combined,
  output logic                   pin_out
);
  logic long_eff;
  logic next_combined;
  logic next_pin;

  always_comb begin
    unique case (beh)
      `DTC_BEH_FORCE0: long_eff = 1'b0;
      `DTC_BEH_FORCE1: long_eff = 1'b1;
      default:         long_eff = long_in;
    endcase
    unique case (func)
      `DTC_FUNC_AND: next_combined = short_in & long_eff;
      `DTC_FUNC_OR:  next_combined = short_in | long_eff;
      `DTC_FUNC_NOR: next_combined = !(short_in | long_eff);
      default:       next_combined = !(short_in & long_eff);
    endcase
    next_pin = (tx_mode && route_en) ? next_combined : port_data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      combined <= 1'b0;
      pin_out  <= 1'b0;
    end else begin
      combined <= next_combined;
      pin_out  <= next_pin;
    end
  end
endmodule

// ==== hw/dtc_ctrl.sv ====
// Purpose: Common control register of the short and long timers
// Assumes: APB slave, one word at index 1 (byte 0x04), pclk at 100 MHz
// Notes: stop_recover is a one-cycle Stop-mode recovery pulse
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_ctrl (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // System
  input  wire logic        stop_recover,
  // Timers
  input  wire logic        short_timer_output,
  input  wire logic        long_timer_output,
  input  wire logic        short_single_pass,
  input  wire logic        long_single_pass,
  output logic             demod_mode,
  output logic             ping_pong_active,
  output logic             short_init_level,
  output logic             long_init_level,
  output logic             capture_rise,
  output logic             capture_fall,
  // Pins
  input  wire logic        port_out_data,
  input  wire logic        demod_input_pin_a,
  input  wire logic        demod_input_pin_b,
  output logic             shared_output_pin,
  output logic             combined_timer_output
);
  logic              route_en;
  dtc_pkg::dtc_sel_t func;
  dtc_pkg::dtc_sel_t beh;
  logic              init_short;
  logic              init_long;
  logic              flag_rise;
  logic              flag_fall;
  logic              next_mode;
  logic              next_route_en;
  dtc_pkg::dtc_sel_t next_func;
  dtc_pkg::dtc_sel_t next_beh;
  logic              next_init_short;
  logic              next_init_long;
  logic              next_flag_rise;
  logic              next_flag_fall;
  logic [31:0]       next_prdata;
  logic              hit;
  logic              wr_en;
  logic              rd_setup;
  dtc_pkg::dtc_byte_t reg_view;
  dtc_pkg::dtc_byte_t wdat;
  logic              demod_raw;
  logic              rise_evt;
  logic              fall_evt;

  // Bus decode; access always completes in one access cycle
  assign hit      = (paddr[7:2] == `DTC_CTRL_INDEX) && (paddr[1:0] == 2'h0);
  assign wr_en    = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign wdat     = pwdata[7:0];

  // Bits 1:0 show flags in demodulation, initial levels in transmit
  always_comb begin
    reg_view = {demod_mode, route_en, func, beh,
                demod_mode ? flag_rise : init_short,
                demod_mode ? flag_fall : init_long};
  end

  always_comb begin
    next_mode       = demod_mode;
    next_route_en   = route_en;
    next_func       = func;
    next_beh        = beh;
    next_init_short = init_short;
    next_init_long  = init_long;
    next_flag_rise  = flag_rise;
    next_flag_fall  = flag_fall;
    if (stop_recover) begin
      // Recovery clears all but the logic field
      next_mode       = 1'b0;
      next_route_en   = 1'b0;
      next_beh        = `DTC_BEH_NORMAL;
      next_init_short = 1'b0;
      next_init_long  = 1'b0;
      next_flag_rise  = 1'b0;
      next_flag_fall  = 1'b0;
    end else if (wr_en) begin
      // Mode is written without checks; timers must already be stopped
      next_mode     = wdat[`DTC_BIT_MODE];
      next_route_en = wdat[`DTC_BIT_ROUTE];
      next_func     = wdat[`DTC_BIT_FUNC_HI:`DTC_BIT_FUNC_LO];
      next_beh      = wdat[`DTC_BIT_BEH_HI:`DTC_BIT_BEH_LO];
      if (demod_mode) begin
        next_flag_rise = flag_rise & !wdat[`DTC_BIT_SHORT];
        next_flag_fall = flag_fall & !wdat[`DTC_BIT_LONG];
      end else begin
        next_init_short = wdat[`DTC_BIT_SHORT];
        next_init_long  = wdat[`DTC_BIT_LONG];
      end
    end
    // Capture beats a clear in the same cycle
    next_flag_rise = next_flag_rise | rise_evt;
    next_flag_fall = next_flag_fall | fall_evt;
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = hit ? {24'h000000, reg_view} : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      demod_mode <= 1'b0;
      route_en   <= 1'b0;
      func       <= `DTC_FUNC_AND;
      beh        <= `DTC_BEH_NORMAL;
      init_short <= 1'b0;
      init_long  <= 1'b0;
      flag_rise  <= 1'b0;
      flag_fall  <= 1'b0;
      prdata     <= 32'h00000000;
    end else begin
      demod_mode <= next_mode;
      route_en   <= next_route_en;
      func       <= next_func;
      beh        <= next_beh;
      init_short <= next_init_short;
      init_long  <= next_init_long;
      flag_rise  <= next_flag_rise;
      flag_fall  <= next_flag_fall;
      prdata     <= next_prdata;
    end
  end

  assign demod_raw = route_en ? demod_input_pin_b : demod_input_pin_a;
  assign ping_pong_active = !demod_mode && (beh == `DTC_BEH_PINGPONG)
                            && short_single_pass && long_single_pass;
  assign short_init_level = init_short;
  assign long_init_level  = init_long;
  assign capture_rise     = rise_evt;
  assign capture_fall     = fall_evt;

  dtc_edge_filter u_edge (
    .pclk     (pclk),
    .presetn  (presetn),
    .enable   (demod_mode),
    .filt_sel (beh),
    .edge_sel (func),
    .raw_in   (demod_raw),
    .rise_evt (rise_evt),
    .fall_evt (fall_evt)
  );

  dtc_out_logic u_out (
    .pclk      (pclk),
    .presetn   (presetn),
    .tx_mode   (!demod_mode),
    .route_en  (route_en),
    .func      (func),
    .beh       (demod_mode ? `DTC_BEH_NORMAL : beh),
    .short_in  (short_timer_output),
    .long_in   (long_timer_output),
    .port_data (port_out_data),
    .combined  (combined_timer_output),
    .pin_out   (shared_output_pin)
  );

  // Assertion helper: run length of the selected input, saturating at 15
  logic              prev_raw;
  logic              next_prev_raw;
  dtc_pkg::dtc_cnt_t raw_run;
  dtc_pkg::dtc_cnt_t next_raw_run;

  always_comb begin
    next_prev_raw = demod_raw;
    next_raw_run  = 4'h1;
    if (demod_raw == prev_raw) begin
      next_raw_run = (raw_run == 4'hf) ? raw_run : raw_run + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_raw <= 1'b0;
      raw_run  <= 4'h0;
    end else begin
      prev_raw <= next_prev_raw;
      raw_run  <= next_raw_run;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Configuration and Stop recovery
  a_recover_mode: assert property (stop_recover |=> !demod_mode && beh == 2'h0)
    else $error("Stop recovery did not clear mode");
  a_recover_func: assert property (stop_recover |=> func == $past(func))
    else $error("Logic field lost in Stop recovery");
  a_func_hold: assert property (!wr_en |=> func == $past(func))
    else $error("Logic field changed without a write");

  // Shared pin: one cycle behind its sources
  a_pin_port: assert property ((demod_mode || !route_en)
    |=> shared_output_pin == $past(port_out_data))
    else $error("Shared pin not following port data");
  a_pin_and: assert property ((!demod_mode && route_en && func == 2'h0 && beh == 2'h0)
    |=> shared_output_pin == ($past(short_timer_output) & $past(long_timer_output)))
    else $error("AND combination wrong");
  a_pin_or: assert property ((!demod_mode && route_en && func == 2'h1 && beh == 2'h0)
    |=> shared_output_pin == ($past(short_timer_output) | $past(long_timer_output)))
    else $error("OR combination wrong");
  a_pin_nor: assert property ((!demod_mode && route_en && func == 2'h2 && beh == 2'h0)
    |=> shared_output_pin == !($past(short_timer_output) | $past(long_timer_output)))
    else $error("NOR combination wrong");
  a_pin_nand: assert property ((!demod_mode && route_en && func == 2'h3 && beh == 2'h0)
    |=> shared_output_pin == !($past(short_timer_output) & $past(long_timer_output)))
    else $error("NAND combination wrong");
  a_force_zero: assert property ((!demod_mode && route_en && func == 2'h0 && beh == 2'h2)
    |=> shared_output_pin == 1'b0)
    else $error("Forced long output not zero");
  a_force_one: assert property ((!demod_mode && route_en && func == 2'h0 && beh == 2'h3)
    |=> shared_output_pin == $past(short_timer_output))
    else $error("Forced long output not one");

  // Edge capture and its flags
  a_src_pin_a: assert property ((demod_mode && !route_en && func == 2'h2
    && !$past(route_en) && beh == 2'h0 && $past(beh) == 2'h0 && $changed(demod_input_pin_a))
    |=> capture_rise || capture_fall)
    else $error("Edge on input pin a missed");
  a_edge_none: assert property (func == 2'h3 |=> !capture_rise && !capture_fall)
    else $error("Reserved edge code captured");
  a_fall_only: assert property (func == 2'h0 |=> !capture_rise)
    else $error("Rise captured in falling mode");
  a_rise_only: assert property (func == 2'h1 |=> !capture_fall)
    else $error("Fall captured in rising mode");
  a_tx_quiet: assert property (!demod_mode |=> !capture_rise && !capture_fall)
    else $error("Capture in transmit mode");
  a_rise_flag: assert property (capture_rise |=> flag_rise)
    else $error("Rise capture lost");
  a_fall_flag: assert property (capture_fall |=> flag_fall)
    else $error("Fall capture lost");
  a_rise_clear: assert property ((wr_en && demod_mode && pwdata[1] && !rise_evt
    && !stop_recover) |=> !flag_rise)
    else $error("Rise flag not cleared");
  a_fall_clear: assert property ((wr_en && demod_mode && pwdata[0] && !fall_evt
    && !stop_recover) |=> !flag_fall)
    else $error("Fall flag not cleared");
  a_fall_keep: assert property ((wr_en && demod_mode && !pwdata[0] && flag_fall
    && !stop_recover) |=> flag_fall)
    else $error("Fall flag cleared by zero");

  // Initial levels and read-back
  a_init_short: assert property ((wr_en && !demod_mode && !stop_recover)
    |=> short_init_level == $past(pwdata[1]))
    else $error("Short initial level not written");
  a_init_long: assert property ((wr_en && !demod_mode && !stop_recover)
    |=> long_init_level == $past(pwdata[0]))
    else $error("Long initial level not written");
  a_init_keep: assert property ((wr_en && demod_mode && !stop_recover)
    |=> {short_init_level, long_init_level} == $past({init_short, init_long}))
    else $error("Initial levels changed in demodulation");
  a_read_mode: assert property ((rd_setup && hit) |=> prdata[7] == $past(demod_mode))
    else $error("Mode bit read back wrong");
  a_read_flags: assert property ((rd_setup && hit && demod_mode)
    |=> prdata[1:0] == $past({flag_rise, flag_fall}))
    else $error("Edge flags read back wrong");
  a_read_init: assert property ((rd_setup && hit && !demod_mode)
    |=> prdata[1:0] == $past({init_short, init_long}))
    else $error("Initial levels read back wrong");

  // Ping-pong and noise filter
  a_pingpong_tx: assert property (ping_pong_active |-> !demod_mode && beh == 2'h1)
    else $error("Ping-pong outside transmit");
  a_pp_single: assert property ((beh == 2'h1 && !(short_single_pass && long_single_pass))
    |-> !ping_pong_active)
    else $error("Ping-pong without single-pass timers");
  a_rise_filter: assert property ((demod_mode && beh == 2'h1 && !demod_raw)
    |=> !capture_rise [*3])
    else $error("Rise passed short filter early");
  a_filter_short: assert property (((capture_rise || capture_fall) && $past(beh) == 2'h1)
    |-> raw_run >= 4'h4)
    else $error("Edge accepted before 4 stable cycles");
  a_filter_long: assert property (((capture_rise || capture_fall) && $past(beh) == 2'h2)
    |-> raw_run >= 4'h8)
    else $error("Edge accepted before 8 stable cycles");
endmodule

// ==== verif/dtc_carrier_model.sv ====
// Purpose: Far-side source of the demodulated input on pins a and b
// Assumes: burst is called right after a rising pclk edge
// Notes: Pins are plain levels, held low between bursts
`timescale 1ns/1ps
module dtc_carrier_model (
  // Clock
  input  wire logic pclk,
  // Pins
  output logic      pin_a,
  output logic      pin_b
);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // One high burst of w cycles; short ones probe the noise filter
  task automatic burst(input logic sel, input int w);
    if (sel) pin_b <= 1'b1;
    else pin_a <= 1'b1;
    repeat (w) @(posedge pclk);
    pin_a <= 1'b0;
    pin_b <= 1'b0;
  endtask
endmodule

// ==== verif/dtc_ctrl_tb.sv ====
// Purpose: Self-checking bench of the timer common control register
// Assumes: Register at byte 0x04; the master waits for pready
// Notes: Timer inputs stay idle across every mode change
`timescale 1ns/1ps
module dtc_ctrl_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic        pready, pslverr, e, s_out = 0, l_out = 0, s_sp = 0, l_sp = 0;
  logic        stop_rec = 0, port_d = 0, pin_a, pin_b, mode, ppa, s_init, l_init;
  logic        cap_r, cap_f, pin_o, comb;
  logic [31:0] n_rise, n_fall;
  int          err_count = 0, n_tests = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    n_rise += cap_r;
    n_fall += cap_f;
  end

  dtc_carrier_model u_car (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));
  dtc_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .stop_recover(stop_rec), .short_timer_output(s_out), .long_timer_output(l_out),
    .short_single_pass(s_sp), .long_single_pass(l_sp), .demod_mode(mode),
    .ping_pong_active(ppa), .short_init_level(s_init), .long_init_level(l_init),
    .capture_rise(cap_r), .capture_fall(cap_f), .port_out_data(port_d),
    .demod_input_pin_a(pin_a), .demod_input_pin_b(pin_b), .shared_output_pin(pin_o),
    .combined_timer_output(comb)
  );

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a slave that never answers
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] d);
    apb(1'b1, 8'h04, d);
  endtask

  function automatic logic ex(input logic [1:0] f, input logic s, input logic l);
    case (f)
      2'h0: ex = s & l;
      2'h1: ex = s | l;
      2'h2: ex = ~(s | l);
      default: ex = ~(s & l);
    endcase
  endfunction

  task automatic dm(input logic [7:0] c, input logic sel, input int w, input int r, input int f);
    wr(c | 8'h03);
    n_rise = 0;
    n_fall = 0;
    u_car.burst(sel, w);
    repeat (16) @(posedge pclk);
    chk("rise_count", n_rise, r);
    chk("fall_count", n_fall, f);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 8'h00);
    chk("reset_value", v, 32'h0);
    apb(1'b1, 8'h08, 8'hff);
    chk("unmapped_err", e, 1'b1);
    apb(1'b0, 8'h08, 8'h00);
    chk("unmapped_read", v, 32'h0);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      wr(8'h40 | 8'(f << 4));
      for (int k = 0; k < 4; k++) begin
        s_out <= k[1];
        l_out <= k[0];
        repeat (2) @(posedge pclk);
        chk("pin_logic", pin_o, ex(f[1:0], k[1], k[0]));
        chk("combined", comb, ex(f[1:0], k[1], k[0]));
      end
    end
    wr(8'h48);
    s_out <= 1'b1;
    l_out <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("force_low", pin_o, 1'b0);
    wr(8'h4c);
    l_out <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("force_high", pin_o, 1'b1);
    wr(8'h00);
    port_d <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("port_route", pin_o, 1'b1);
    $display("test output done");
    wr(8'h03);
    apb(1'b0, 8'h04, 8'h00);
    chk("init_read", v, 32'h3);
    chk("init_levels", {s_init, l_init}, 2'h3);
    s_sp <= 1'b1;
    l_sp <= 1'b1;
    wr(8'h04);
    chk("ping_pong", ppa, 1'b1);
    l_sp <= 1'b0;
    @(posedge pclk);
    chk("ping_pong_multi", ppa, 1'b0);
    wr(8'h77);
    stop_rec <= 1'b1;
    @(posedge pclk);
    stop_rec <= 1'b0;
    @(posedge pclk);
    apb(1'b0, 8'h04, 8'h00);
    chk("stop_keep", v, 32'h30);
    port_d <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h04, 8'h00);
    chk("hw_reset", v, 32'h0);
    wr(8'h00);
    $display("test transmit done");
    s_out <= 1'b0;
    wr(8'ha0);
    chk("demod_mode", mode, 1'b1);
    n_rise = 0;
    u_car.burst(1'b0, 5);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h04, 8'h00);
    chk("flags", v, 32'ha3);
    wr(8'ha2);
    apb(1'b0, 8'h04, 8'h00);
    chk("w1c", v, 32'ha1);
    for (int k = 0; k < 4; k++) begin
      dm(8'h80 | 8'(k << 4), 1'b0, 5, (k == 1 || k == 2), (k == 0 || k == 2));
    end
    dm(8'he4, 1'b1, 3, 0, 0);
    dm(8'he4, 1'b1, 6, 1, 1);
    dm(8'he4, 1'b0, 6, 0, 0);
    dm(8'he8, 1'b1, 7, 0, 0);
    dm(8'he8, 1'b1, 11, 1, 1);
    dm(8'hac, 1'b0, 5, 1, 1);
    $display("test demod done");
    summarize();
  end
endmodule
